// file: src/aspct_device.sv
// Converter end of the serial command port, timed in master clock periods
// Summary of operation
// - Host never holds clock high nine data periods outside the reset pattern
// - Input bit sampled on serial clock falling edge
// - Read-registers readback waits fifty master clocks
// - New output bit after each rising edge
// - Output released six to ten clocks after fall
// - Output released at once when select rises
// - Select held low eight clocks after fall
// - Four clocks between short commands
// - Twenty-four clocks after continuous-read or sync commands
// - Sync/powerdown and reset inputs are active low
// - Data-ready output low means new result
// - Gpio zero pin shared with clock output
// - Three-pulse serial clock pattern resets device
// - Result invalid sixteen clocks while updating
`timescale 1ns/1ns
module aspct_device #(
  parameter int CLKOUT_HALF_CYC = 1
) (
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  // Serial port pins
  aspct_if.device          port,
  // Result and readback data
  input  wire logic        result_strobe_in,
  input  aspct_pkg::aspct_byte_t tx_byte_in,
  output aspct_pkg::aspct_byte_t rx_byte_out,
  output logic             rx_valid_out,
  output logic             pattern_reset_out,
  // Shared gpio0 / clock output pin
  input  wire logic        clkout_enable_in,
  input  wire logic        gpio0_drive_in,
  input  wire logic        gpio0_value_in,
  input  wire logic        gpio0_clock_out_in,
  output logic             gpio0_clock_out_out,
  output logic             gpio0_clock_out_oe_n_out,
  output logic             gpio0_read_out
);
  import aspct_pkg::*;

  aspct_dev_s s_r;
  aspct_dev_s s_nxt;
  logic [5:0] sync_w;
  logic       sy_cs_n;
  logic       sy_sclk;
  logic       sy_din;
  logic       sy_apd_n;
  logic       sy_rst_n;
  logic       sy_gpio;
  logic       sclk_rise;
  logic       sclk_fall;

  function automatic logic in_win(input aspct_cnt_t c, input int lo, input int hi);
    in_win = (c >= aspct_cnt_t'(lo)) && (c <= aspct_cnt_t'(hi));
  endfunction : in_win

  // All pins from the host cross through the same depth, so data stays aligned to clock
  aspct_sync #(
    .W (6)
  ) u_sync (
    .clk_in   (clk_in),
    .rst_in   (rst_in),
    .async_in ({port.cs_n, port.sclk, port.din, port.align_powerdown_n,
                port.hard_reset_n, gpio0_clock_out_in}),
    .sync_out (sync_w)
  );

  assign sy_cs_n   = sync_w[5];
  assign sy_sclk   = sync_w[4];
  assign sy_din    = sync_w[3];
  assign sy_apd_n  = sync_w[2];
  assign sy_rst_n  = sync_w[1];
  assign sy_gpio   = sync_w[0];
  assign sclk_rise = sy_sclk & ~s_r.sclk_d;
  assign sclk_fall = ~sy_sclk & s_r.sclk_d;

  always_comb begin
    s_nxt           = s_r;
    s_nxt.rx_valid  = 1'h0;
    s_nxt.pat_reset = 1'h0;
    s_nxt.sclk_d    = sy_sclk;
    s_nxt.gpio_rd   = sy_gpio;

    // Serial shifting; select high idles the port
    if (sy_cs_n) begin
      s_nxt.dout_oe_n = 1'h1;
      s_nxt.hiz_run   = 1'h0;
      s_nxt.rx_cnt    = 3'h0;
      s_nxt.tx_sh     = tx_byte_in;
    end else begin
      if (sclk_rise) begin
        s_nxt.dout      = s_r.tx_sh[7];
        s_nxt.tx_sh     = {s_r.tx_sh[6:0], 1'h0};
        s_nxt.dout_oe_n = 1'h0;
        s_nxt.hiz_run   = 1'h0;
      end
      if (sclk_fall) begin
        s_nxt.rx_sh   = {s_r.rx_sh[6:0], sy_din};
        s_nxt.rx_cnt  = s_r.rx_cnt + 3'h1;
        s_nxt.hiz_run = 1'h1;
        s_nxt.hiz_cnt = 4'h0;
        if (s_r.rx_cnt == 3'h7) begin
          s_nxt.rx_byte  = {s_r.rx_sh[6:0], sy_din};
          s_nxt.rx_valid = 1'h1;
          s_nxt.tx_sh    = tx_byte_in;
        end
      end else if (s_r.hiz_run) begin
        // Counted from the detected edge; sync delay makes up the rest of the window
        s_nxt.hiz_cnt = s_r.hiz_cnt + 4'h1;
        if (s_r.hiz_cnt == 4'(DOUT_HIZ_CNT - 1)) begin
          s_nxt.dout_oe_n = 1'h1;
          s_nxt.hiz_run   = 1'h0;
        end
      end
    end

    // Clock pattern reset detector, independent of select
    if (sclk_rise) begin
      s_nxt.hi_cnt = aspct_cnt_t'(1);
      if (s_r.lo_cnt < aspct_cnt_t'(PAT_LOW_MIN_TAU)) begin
        s_nxt.pat_stage = 2'h0;
      end
    end else if (sy_sclk && s_r.hi_cnt != '1) begin
      s_nxt.hi_cnt = s_r.hi_cnt + aspct_cnt_t'(1);
    end
    if (sclk_fall) begin
      s_nxt.lo_cnt = aspct_cnt_t'(1);
      case (s_r.pat_stage)
        2'h0: begin
          s_nxt.pat_stage = in_win(s_r.hi_cnt, PAT1_MIN_TAU, PAT1_MAX_TAU) ? 2'h1 : 2'h0;
        end
        2'h1: begin
          if (in_win(s_r.hi_cnt, PAT2_MIN_TAU, PAT2_MAX_TAU)) begin
            s_nxt.pat_stage = 2'h2;
          end else begin
            s_nxt.pat_stage = in_win(s_r.hi_cnt, PAT1_MIN_TAU, PAT1_MAX_TAU) ? 2'h1 : 2'h0;
          end
        end
        2'h2: begin
          s_nxt.pat_stage = 2'h0;
          s_nxt.pat_reset = in_win(s_r.hi_cnt, PAT3_MIN_TAU, PAT3_MAX_TAU);
        end
        default: begin
          s_nxt.pat_stage = 2'h0;
        end
      endcase
    end else if (!sy_sclk && s_r.lo_cnt != '1) begin
      s_nxt.lo_cnt = s_r.lo_cnt + aspct_cnt_t'(1);
    end

    // Result update window; powerdown low holds the result off
    if (!sy_apd_n) begin
      s_nxt.result_available_n_n  = 1'h1;
      s_nxt.inv_cnt = 5'h0;
    end else if (result_strobe_in) begin
      s_nxt.result_available_n_n  = 1'h1;
      s_nxt.inv_cnt = 5'(INVALID_CYC);
    end else if (s_r.inv_cnt != 5'h0) begin
      s_nxt.inv_cnt = s_r.inv_cnt - 5'h1;
      if (s_r.inv_cnt == 5'h1) begin
        s_nxt.result_available_n_n = 1'h0;
      end
    end

    // Clock output divider runs only while clkout_enable_in is high, to save toggling
    if (clkout_enable_in) begin
      if (s_r.div_cnt >= 8'(CLKOUT_HALF_CYC - 1)) begin
        s_nxt.div_cnt = 8'h0;
        s_nxt.clk_tog = ~s_r.clk_tog;
      end else begin
        s_nxt.div_cnt = s_r.div_cnt + 8'h1;
      end
      s_nxt.gpio_o    = s_r.clk_tog;
      s_nxt.gpio_oe_n = 1'h0;
    end else begin
      s_nxt.div_cnt   = 8'h0;
      s_nxt.clk_tog   = 1'h0;
      s_nxt.gpio_o    = gpio0_value_in;
      s_nxt.gpio_oe_n = ~gpio0_drive_in;
    end

    // Reset pin low or a detected pattern restarts the port logic
    if (!sy_rst_n || s_r.pat_reset) begin
      s_nxt           = DEV_RST;
      s_nxt.sclk_d    = sy_sclk;
      s_nxt.gpio_rd   = sy_gpio;
      s_nxt.pat_reset = 1'h0;
      // Line is released anyway; holding the bit keeps the data register from glitching
      s_nxt.dout      = s_r.dout;
      s_nxt.gpio_o    = gpio0_value_in;
      s_nxt.gpio_oe_n = ~gpio0_drive_in;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      s_r <= DEV_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign port.dout               = s_r.dout;
  assign port.dout_oe_n          = s_r.dout_oe_n;
  assign port.result_available_n = s_r.result_available_n_n;
  assign rx_byte_out             = s_r.rx_byte;
  assign rx_valid_out            = s_r.rx_valid;
  assign pattern_reset_out       = s_r.pat_reset;
  assign gpio0_clock_out_out     = s_r.gpio_o;
  assign gpio0_clock_out_oe_n_out = s_r.gpio_oe_n;
  assign gpio0_read_out          = s_r.gpio_rd;
endmodule : aspct_device

// file: src/aspct_host.sv
// Host end of the serial command port: clock generator and command gap timer
`timescale 1ns/1ns
module aspct_host #(
  parameter int HALF_CYC = aspct_pkg::SCLK_HALF_CYC
) (
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  // Serial port pins
  aspct_if.host            port,
  // Command request
  input  wire logic        cmd_valid_in,
  input  aspct_pkg::aspct_byte_t cmd_byte_in,
  input  aspct_pkg::aspct_kind_e cmd_kind_in,
  input  wire logic        cmd_last_in,
  output logic             ready_out,
  // Readback and status
  output aspct_pkg::aspct_byte_t rx_byte_out,
  output logic             rx_valid_out,
  output logic             data_ready_out,
  // Device control pins, requests active high
  input  wire logic        powerdown_req_in,
  input  wire logic        reset_req_in
);
  import aspct_pkg::*;

  aspct_host_s s_r;
  aspct_host_s s_nxt;
  logic [1:0]  sync_w;
  logic        sy_dout;
  logic        sy_result_available_n_n;
  logic        gap_done;

  function automatic aspct_cnt_t gap_of(input aspct_kind_e k);
    case (k)
      KIND_READ_REGISTERS_CMD: gap_of = aspct_cnt_t'(READ_REGISTERS_CMD_GAP_CYC);
      KIND_LONG: gap_of = aspct_cnt_t'(LONG_GAP_CYC);
      KIND_RESULT_AVAILABLE_N: gap_of = aspct_cnt_t'(LONG_GAP_CYC);
      KIND_PATTERN: gap_of = aspct_cnt_t'(LONG_GAP_CYC);
      default: gap_of = aspct_cnt_t'(SHORT_GAP_CYC);
    endcase
  endfunction : gap_of

  function automatic aspct_cnt_t pat_len(input logic [1:0] idx);
    case (idx)
      2'h0: pat_len = aspct_cnt_t'(PAT1_GEN_CYC);
      2'h1: pat_len = aspct_cnt_t'(PAT2_GEN_CYC);
      default: pat_len = aspct_cnt_t'(PAT3_GEN_CYC);
    endcase
  endfunction : pat_len

  aspct_sync #(
    .W (2)
  ) u_sync (
    .clk_in   (clk_in),
    .rst_in   (rst_in),
    .async_in ({port.dout_line, port.result_available_n}),
    .sync_out (sync_w)
  );

  assign sy_dout   = sync_w[1];
  assign sy_result_available_n_n = sync_w[0];
  // Result-available commands also wait for a fresh result flag
  assign gap_done  = (s_r.cnt >= gap_of(s_r.kind))
                   && (s_r.kind != KIND_RESULT_AVAILABLE_N || !sy_result_available_n_n)
                   && (!s_r.last || s_r.cnt >= aspct_cnt_t'(CS_HOLD_CYC));

  always_comb begin
    s_nxt            = s_r;
    s_nxt.rx_valid   = 1'h0;
    s_nxt.apd_n      = ~powerdown_req_in;
    s_nxt.rst_n      = ~reset_req_in;
    s_nxt.data_ready = ~sy_result_available_n_n;
    // Saturates so a long wait for the result flag cannot wrap below the gap
    s_nxt.cnt        = (s_r.cnt == '1) ? s_r.cnt : s_r.cnt + aspct_cnt_t'(1);
    case (s_r.st)
      H_IDLE: begin
        s_nxt.ready = 1'h1;
        if (cmd_valid_in && s_r.ready) begin
          s_nxt.ready   = 1'h0;
          s_nxt.cs_n    = 1'h0;
          s_nxt.sclk    = 1'h1;
          s_nxt.cnt     = '0;
          s_nxt.kind    = cmd_kind_in;
          s_nxt.last    = cmd_last_in;
          s_nxt.bit_cnt = 3'h0;
          s_nxt.pat_idx = 2'h0;
          if (cmd_kind_in == KIND_PATTERN) begin
            s_nxt.st   = H_PAT_HI;
            s_nxt.last = 1'h1;
          end else begin
            s_nxt.st    = H_BIT_HI;
            s_nxt.din   = cmd_byte_in[7];
            s_nxt.tx_sh = {cmd_byte_in[6:0], 1'h0};
          end
        end
      end
      H_BIT_HI: begin
        // Fixed half period keeps each high level far below the long-high limit
        if (s_r.cnt == aspct_cnt_t'(HALF_CYC - 1)) begin
          s_nxt.sclk = 1'h0;
          s_nxt.cnt  = '0;
          s_nxt.st   = H_BIT_LO;
        end
      end
      H_BIT_LO: begin
        if (s_r.cnt == aspct_cnt_t'(HALF_CYC - 1)) begin
          s_nxt.rx_sh = {s_r.rx_sh[6:0], sy_dout};
          if (s_r.bit_cnt == 3'h7) begin
            s_nxt.rx_byte  = {s_r.rx_sh[6:0], sy_dout};
            s_nxt.rx_valid = 1'h1;
            s_nxt.cnt      = aspct_cnt_t'(HALF_CYC);
            s_nxt.st       = H_GAP;
          end else begin
            s_nxt.bit_cnt = s_r.bit_cnt + 3'h1;
            s_nxt.sclk    = 1'h1;
            s_nxt.din     = s_r.tx_sh[7];
            s_nxt.tx_sh   = {s_r.tx_sh[6:0], 1'h0};
            s_nxt.cnt     = '0;
            s_nxt.st      = H_BIT_HI;
          end
        end
      end
      H_GAP: begin
        if (gap_done) begin
          s_nxt.cs_n = s_r.last ? 1'h1 : 1'h0;
          s_nxt.st   = H_IDLE;
        end
      end
      H_PAT_HI: begin
        if (s_r.cnt == pat_len(s_r.pat_idx) - aspct_cnt_t'(1)) begin
          s_nxt.sclk = 1'h0;
          s_nxt.cnt  = '0;
          s_nxt.st   = H_PAT_LO;
        end
      end
      H_PAT_LO: begin
        if (s_r.cnt == aspct_cnt_t'(PAT_LOW_GEN_CYC - 1)) begin
          s_nxt.cnt = '0;
          if (s_r.pat_idx == 2'h2) begin
            s_nxt.st = H_GAP;
          end else begin
            s_nxt.pat_idx = s_r.pat_idx + 2'h1;
            s_nxt.sclk    = 1'h1;
            s_nxt.st      = H_PAT_HI;
          end
        end
      end
      default: begin
        s_nxt = HOST_RST;
      end
    endcase
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      s_r <= HOST_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign port.cs_n              = s_r.cs_n;
  assign port.sclk              = s_r.sclk;
  assign port.din               = s_r.din;
  assign port.align_powerdown_n = s_r.apd_n;
  assign port.hard_reset_n      = s_r.rst_n;
  assign ready_out              = s_r.ready;
  assign rx_byte_out            = s_r.rx_byte;
  assign rx_valid_out           = s_r.rx_valid;
  assign data_ready_out         = s_r.data_ready;
endmodule : aspct_host

// file: src/aspct_if.sv
// Serial command port wires between converter and host
`timescale 1ns/1ns
interface aspct_if;
  logic cs_n;
  logic sclk;
  logic din;
  logic dout;
  logic dout_oe_n;
  logic dout_line;
  logic result_available_n;
  logic align_powerdown_n;
  logic hard_reset_n;

  // Released output reads high, as with a pull-up
  assign dout_line = dout_oe_n ? 1'h1 : dout;

  modport device (
    input  cs_n, sclk, din, align_powerdown_n, hard_reset_n,
    output dout, dout_oe_n, result_available_n
  );
  modport host (
    output cs_n, sclk, din, align_powerdown_n, hard_reset_n,
    input  dout_line, result_available_n
  );
endinterface : aspct_if

// file: src/aspct_pkg.sv
// Shared constants, types and reset values for the converter serial command port
package aspct_pkg;
  localparam int CLK_HZ            = 10_000_000;
  localparam int CLK_NS            = 1_000_000_000 / CLK_HZ;
  localparam int TAU_NS            = CLK_NS;
  localparam int SYNC_LAT_CYC      = 3;
  localparam int SCLK_HIGH_MIN_NS  = 200;
  localparam int SCLK_HIGH_MIN_CYC = (SCLK_HIGH_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int SCLK_HALF_CYC     = 4 * SCLK_HIGH_MIN_CYC;
  localparam int READ_REGISTERS_CMD_GAP_TAU      = 50;
  localparam int READ_REGISTERS_CMD_GAP_CYC      = (READ_REGISTERS_CMD_GAP_TAU * TAU_NS + CLK_NS - 1) / CLK_NS;
  localparam int SHORT_GAP_TAU     = 4;
  localparam int SHORT_GAP_CYC     = (SHORT_GAP_TAU * TAU_NS + CLK_NS - 1) / CLK_NS;
  localparam int LONG_GAP_TAU      = 24;
  localparam int LONG_GAP_CYC      = (LONG_GAP_TAU * TAU_NS + CLK_NS - 1) / CLK_NS;
  localparam int CS_HOLD_TAU       = 8;
  localparam int CS_HOLD_CYC       = (CS_HOLD_TAU * TAU_NS + CLK_NS - 1) / CLK_NS;
  localparam int DOUT_HIZ_MIN_TAU  = 6;
  localparam int DOUT_HIZ_MAX_TAU  = 10;
  localparam int DOUT_HIZ_MIN_CYC  = (DOUT_HIZ_MIN_TAU * TAU_NS + CLK_NS - 1) / CLK_NS;
  localparam int DOUT_HIZ_MAX_CYC  = DOUT_HIZ_MAX_TAU * TAU_NS / CLK_NS;
  localparam int DOUT_HIZ_CNT      = (DOUT_HIZ_MIN_CYC + DOUT_HIZ_MAX_CYC) / 2 - SYNC_LAT_CYC - 1;
  localparam int INVALID_TAU       = 16;
  localparam int INVALID_CYC       = (INVALID_TAU * TAU_NS + CLK_NS - 1) / CLK_NS;
  localparam int PAT_LOW_MIN_TAU   = 5;
  localparam int PAT1_MIN_TAU      = 300;
  localparam int PAT1_MAX_TAU      = 500;
  localparam int PAT2_MIN_TAU      = 550;
  localparam int PAT2_MAX_TAU      = 750;
  localparam int PAT3_MIN_TAU      = 1050;
  localparam int PAT3_MAX_TAU      = 1250;
  localparam int PAT1_GEN_CYC      = (PAT1_MIN_TAU + PAT1_MAX_TAU) / 2;
  localparam int PAT2_GEN_CYC      = (PAT2_MIN_TAU + PAT2_MAX_TAU) / 2;
  localparam int PAT3_GEN_CYC      = (PAT3_MIN_TAU + PAT3_MAX_TAU) / 2;
  localparam int PAT_LOW_GEN_CYC   = 2 * PAT_LOW_MIN_TAU;
  localparam int CNT_W             = 11;

  typedef logic [CNT_W-1:0] aspct_cnt_t;
  typedef logic [7:0]       aspct_byte_t;

  typedef enum logic [2:0] {
    KIND_SHORT   = 3'h0,
    KIND_READ_REGISTERS_CMD    = 3'h1,
    KIND_LONG    = 3'h2,
    KIND_RESULT_AVAILABLE_N    = 3'h3,
    KIND_PATTERN = 3'h4
  } aspct_kind_e;

  typedef enum logic [2:0] {
    H_IDLE   = 3'h0,
    H_BIT_HI = 3'h1,
    H_BIT_LO = 3'h2,
    H_GAP    = 3'h3,
    H_PAT_HI = 3'h4,
    H_PAT_LO = 3'h5
  } aspct_hst_e;

  typedef struct packed {
    aspct_byte_t rx_sh;
    logic [2:0]  rx_cnt;
    aspct_byte_t tx_sh;
    aspct_byte_t rx_byte;
    logic        rx_valid;
    logic        dout;
    logic        dout_oe_n;
    logic        hiz_run;
    logic [3:0]  hiz_cnt;
    logic        sclk_d;
    aspct_cnt_t  hi_cnt;
    aspct_cnt_t  lo_cnt;
    logic [1:0]  pat_stage;
    logic        pat_reset;
    logic [4:0]  inv_cnt;
    logic        result_available_n_n;
    logic [7:0]  div_cnt;
    logic        clk_tog;
    logic        gpio_o;
    logic        gpio_oe_n;
    logic        gpio_rd;
  } aspct_dev_s;

  localparam aspct_dev_s DEV_RST = '{dout_oe_n: 1'h1, result_available_n_n: 1'h1, gpio_oe_n: 1'h1,
                                     default: '0};

  typedef struct packed {
    aspct_hst_e  st;
    aspct_cnt_t  cnt;
    logic [2:0]  bit_cnt;
    logic [1:0]  pat_idx;
    aspct_byte_t tx_sh;
    aspct_byte_t rx_sh;
    aspct_byte_t rx_byte;
    logic        rx_valid;
    aspct_kind_e kind;
    logic        last;
    logic        cs_n;
    logic        sclk;
    logic        din;
    logic        apd_n;
    logic        rst_n;
    logic        ready;
    logic        data_ready;
  } aspct_host_s;

  localparam aspct_host_s HOST_RST = '{st: H_IDLE, kind: KIND_SHORT, cs_n: 1'h1, apd_n: 1'h1,
                                       rst_n: 1'h1, ready: 1'h1, default: '0};
endpackage : aspct_pkg

// file: src/aspct_sync.sv
// Three-flop input synchroniser with second/third agreement filter
`timescale 1ns/1ns
module aspct_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clk_in,
  input  wire logic         rst_in,
  // Async inputs and filtered outputs
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  import aspct_pkg::*;

  typedef struct packed {
    logic [W-1:0] ff1;
    logic [W-1:0] ff2;
    logic [W-1:0] ff3;
    logic [W-1:0] val;
  } aspct_sync_s;

  aspct_sync_s s_r;
  aspct_sync_s s_nxt;

  always_comb begin
    s_nxt     = s_r;
    s_nxt.ff1 = async_in;
    s_nxt.ff2 = s_r.ff1;
    s_nxt.ff3 = s_r.ff2;
    // First flop feeds only the second; agreement masks a metastable bit
    for (int i = 0; i < W; i++) begin
      if (s_r.ff2[i] == s_r.ff3[i]) begin
        s_nxt.val[i] = s_r.ff3[i];
      end
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign sync_out = s_r.val;
endmodule : aspct_sync

// file: test/aspct_properties.sv
// Concurrent checks on the serial command port wires
`timescale 1ns/1ns
module aspct_properties (
  // Clock and reset
  input  wire logic clk_in,
  input  wire logic rst_in,
  // Port wires
  input  wire logic cs_n,
  input  wire logic sclk,
  input  wire logic din,
  input  wire logic dout,
  input  wire logic dout_oe_n,
  input  wire logic result_available_n,
  input  wire logic align_powerdown_n,
  input  wire logic hard_reset_n
);
  logic [4:0] hi_len_r;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  // Saturates so a long idle high never wraps into a false short window
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) hi_len_r <= 5'h1f;
    else if (!result_available_n) hi_len_r <= 5'h00;
    else if (hi_len_r != 5'h1f) hi_len_r <= hi_len_r + 5'h01;
  end

  a_din_held_fall: assert property (
    $fell(sclk) |-> $stable(din)) else $error("din moved at sclk fall");
  a_dout_quiet_low: assert property (
    $fell(sclk) && !dout_oe_n |=> $stable(dout)[*6]) else $error("dout moved while sclk low");
  a_release_not_early: assert property (
    $fell(sclk) && !dout_oe_n |=> (!dout_oe_n)[*5]) else $error("dout released too early");
  a_release_by_ten: assert property (
    $fell(sclk) ##0 (!sclk)[*8] ##1 (!sclk)[*3] |-> dout_oe_n) else $error("dout not released");
  a_release_on_select: assert property (
    $rose(cs_n) |-> ##[0:5] dout_oe_n) else $error("dout held after select rise");
  a_select_hold: assert property (
    $fell(sclk) |-> (!cs_n)[*8]) else $error("select rose too soon");
  a_low_before_rise: assert property (
    $fell(sclk) |-> (!sclk)[*4]) else $error("sclk rose too soon");
  a_powerdown_holds: assert property (
    (!align_powerdown_n)[*6] |-> result_available_n) else $error("result flagged in powerdown");
  a_hard_reset_quiet: assert property (
    (!hard_reset_n)[*6] |-> dout_oe_n && result_available_n) else $error("outputs live in reset");
  a_invalid_window: assert property (
    $fell(result_available_n) |-> hi_len_r >= 5'h10) else $error("invalid window too short");

  c_select_rise: cover property ($rose(cs_n));
  c_result_new: cover property ($fell(result_available_n));
  c_dout_release: cover property ($rose(dout_oe_n));
endmodule : aspct_properties

// file: test/testbench.sv
// Self-checking bench joining host and converter ends of the port
`timescale 1ns/1ns
module testbench;
  import aspct_pkg::*;
  localparam int LIM = 4000;
  logic        clk_in = 1'h0, rst_in = 1'h1;
  logic        cmd_valid = 1'h0, cmd_last = 1'h0, pd_req = 1'h0, rst_req = 1'h0;
  aspct_byte_t cmd_byte = 8'h00, host_rx_b, dev_rx_b, host_rx = 8'h00, dev_rx = 8'h00;
  aspct_kind_e cmd_kind = KIND_SHORT;
  logic        strb = 1'h0, clk_en = 1'h0, g_drive = 1'h0, g_val = 1'h0, pin_drv = 1'h0;
  logic        host_ready, host_rx_v, host_result_available_n, dev_rx_v, pat_out, g_out, g_oe_n, g_rd, v;
  logic        arm = 1'h0;
  wire logic   g_pin = g_oe_n ? pin_drv : g_out;
  int          error_cnt = 0, checks = 0, low_cnt = 0, gap = 0, pat_cnt = 0, n;
  aspct_kind_e kinds [3] = '{KIND_READ_REGISTERS_CMD, KIND_LONG, KIND_SHORT};
  int          need [3] = '{READ_REGISTERS_CMD_GAP_CYC, LONG_GAP_CYC, SHORT_GAP_CYC};

  aspct_if link ();
  aspct_host i_aspct_host (.clk_in(clk_in), .rst_in(rst_in), .port(link),
    .cmd_valid_in(cmd_valid), .cmd_byte_in(cmd_byte), .cmd_kind_in(cmd_kind),
    .cmd_last_in(cmd_last), .ready_out(host_ready), .rx_byte_out(host_rx_b),
    .rx_valid_out(host_rx_v), .data_ready_out(host_result_available_n), .powerdown_req_in(pd_req),
    .reset_req_in(rst_req));
  aspct_device #(.CLKOUT_HALF_CYC(2)) i_aspct_device (.clk_in(clk_in), .rst_in(rst_in),
    .port(link), .result_strobe_in(strb), .tx_byte_in(8'ha5), .rx_byte_out(dev_rx_b),
    .rx_valid_out(dev_rx_v), .pattern_reset_out(pat_out), .clkout_enable_in(clk_en),
    .gpio0_drive_in(g_drive), .gpio0_value_in(g_val), .gpio0_clock_out_in(g_pin),
    .gpio0_clock_out_out(g_out), .gpio0_clock_out_oe_n_out(g_oe_n), .gpio0_read_out(g_rd));
  aspct_properties i_aspct_properties (.clk_in(clk_in), .rst_in(rst_in), .cs_n(link.cs_n),
    .sclk(link.sclk), .din(link.din), .dout(link.dout), .dout_oe_n(link.dout_oe_n),
    .result_available_n(link.result_available_n),
    .align_powerdown_n(link.align_powerdown_n), .hard_reset_n(link.hard_reset_n));

  initial begin
    forever #50 clk_in = ~clk_in;
  end

  // Low-phase length seen before the first rise after arming
  always @(posedge clk_in) begin
    low_cnt <= link.sclk ? 0 : low_cnt + 1;
    if (arm && link.sclk && low_cnt != 0) begin
      gap <= low_cnt;
      arm <= 1'h0;
    end
    if (pat_out === 1'h1) pat_cnt <= pat_cnt + 1;
    if (dev_rx_v === 1'h1) dev_rx <= dev_rx_b;
    if (host_rx_v === 1'h1) host_rx <= host_rx_b;
  end

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic end_sim;
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_sim

  // Bounded wait for the host to accept work again
  task automatic wait_idle;
    int k;
    k = 0;
    @(negedge clk_in);
    while (host_ready !== 1'h1 && k < LIM) begin
      @(negedge clk_in);
      k++;
    end
    if (k >= LIM) begin
      error_cnt++;
      $display("unexpected timeout waiting for host ready");
      end_sim;
    end
  endtask : wait_idle

  // Request raised while ready stands, dropped after the edge that takes it
  task automatic send(input aspct_byte_t b, input aspct_kind_e k, input logic l);
    wait_idle;
    cmd_byte = b;
    cmd_kind = k;
    cmd_last = l;
    cmd_valid = 1'h1;
    @(negedge clk_in);
    cmd_valid = 1'h0;
  endtask : send

  task automatic strobe;
    @(negedge clk_in);
    strb = 1'h1;
    @(negedge clk_in);
    strb = 1'h0;
  endtask : strobe

  // Strobe a result, then count cycles until data-ready falls
  task automatic strobe_wait;
    strobe;
    n = 0;
    while (link.result_available_n !== 1'h0 && n < 100) begin
      @(negedge clk_in);
      n++;
    end
  endtask : strobe_wait

  initial begin
    repeat (10) @(negedge clk_in);
    rst_in = 1'h0;
    clk_en = 1'h1;
    // Reset pin synchroniser holds the device logic for its first edges
    repeat (8) @(negedge clk_in);
    check("gpio oe", g_oe_n, 1'h0);
    v = g_out;
    repeat (2) @(negedge clk_in);
    check("clock out", g_out, !v);
    clk_en = 1'h0;
    for (int i = 0; i < 2; i++) begin
      g_val = i[0];
      g_drive = 1'h1;
      pin_drv = !i[0];
      repeat (4) @(negedge clk_in);
      check("gpio out", g_out, i[0]);
      g_drive = 1'h0;
      repeat (8) @(negedge clk_in);
      check("gpio read", g_rd, !i[0]);
    end
    // Back-to-back bytes under one select; gaps follow the read-registers, long and short command classes
    for (int i = 0; i < 4; i++) begin
      send(8'hc3 + i[7:0], (i < 3) ? kinds[i] : KIND_SHORT, i == 3);
      wait_idle;
      if (i > 0) check("gap", gap >= need[i-1], 1'h1);
      check("device rx", dev_rx, 8'hc3 + i[7:0]);
      check("host rx", host_rx, 8'ha5);
      arm = 1'h1;
    end
    send(8'hf0, KIND_RESULT_AVAILABLE_N, 1'h1);
    // Past the byte and its gap, so only the missing result holds the host
    repeat (300) @(negedge clk_in);
    check("ready before result", host_ready, 1'h0);
    strobe_wait;
    check("invalid cycles", n[7:0], 8'(INVALID_CYC));
    wait_idle;
    check("data ready", host_result_available_n, 1'h1);
    pd_req = 1'h1;
    strobe;
    repeat (40) @(negedge clk_in);
    check("result in powerdown", link.result_available_n, 1'h1);
    pd_req = 1'h0;
    repeat (10) @(negedge clk_in);
    strobe;
    repeat (30) @(negedge clk_in);
    check("result after powerdown", link.result_available_n, 1'h0);
    strobe_wait;
    check("invalid from low", n[7:0], 8'(INVALID_CYC));
    rst_req = 1'h1;
    repeat (10) @(negedge clk_in);
    check("result in hard reset", link.result_available_n, 1'h1);
    check("dout in hard reset", link.dout_line, 1'h1);
    rst_req = 1'h0;
    repeat (10) @(negedge clk_in);
    check("no stray pattern", pat_cnt[7:0], 8'h00);
    send(8'h00, KIND_PATTERN, 1'h1);
    wait_idle;
    check("pattern reset", pat_cnt[7:0], 8'h01);
    end_sim;
  end
endmodule : testbench
